// ==== rtl/eet_regs.svh ====
// Purpose: register offsets, field positions and constants of the event timer
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef EET_REGS_SVH
`define EET_REGS_SVH
// ==========================================================================
// Register byte offsets
`define EET_OFS_COUNT   4'h0
`define EET_OFS_CTRL    4'h4
// ==========================================================================
// Control field positions
`define EET_MODE_HI     7
`define EET_MODE_LO     6
`define EET_RUN_BIT     4
`define EET_EDGE_BIT    3
`define EET_PSC_HI      2
`define EET_PSC_LO      0
// ==========================================================================
// Reset values and limits
`define EET_CTRL_RST    8'h00
`define EET_COUNT_RST   8'h00
`define EET_COUNT_FULL  8'hFF
`define EET_PSC_RST     7'h00
// ==========================================================================
// Bus answers
`define EET_RESP_OKAY   2'h0
`define EET_RESP_SLVERR 2'h2
`endif

// ==== rtl/eet_pkg.sv ====
// Purpose: types shared by the event timer
// Assumes: nothing
// Notes:   constants live in eet_regs.svh
package eet_pkg;
  // ========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    EET_MODE_IDLE  = 2'h0,
    EET_MODE_EVENT = 2'h1,
    EET_MODE_TIMER = 2'h2,
    EET_MODE_PULSE = 2'h3
  } eet_mode_e;
  // Control register layout
  typedef struct packed {
    eet_mode_e   mode;
    logic        rsv;
    logic        run;
    logic        edge_sel;
    logic [2:0]  psc;
  } eet_ctrl_s;
  // Pulse measurement sequencer
  typedef enum logic [2:0] {
    EET_PW_IDLE = 3'h1,
    EET_PW_ARM  = 3'h2,
    EET_PW_MEAS = 3'h4
  } eet_pw_e;
  // Status seen from outside
  typedef struct packed {
    logic        running;
    logic [7:0]  count;
  } eet_stat_s;
endpackage

// ==== rtl/eet_timer.sv ====
// Purpose: 8-bit up-counting timer / event counter / pulse width unit
// Assumes: count pin synchronous to aclk; AXI4-Lite register access
// Notes:   preload register holds no reset value
`timescale 1ns/10ps
`default_nettype none
`include "eet_regs.svh"

// How it works
// - One 8-bit up counter: timer, event counter or pulse width unit.
// - Reading the count register returns the live counter value.
// - Timer and pulse modes count internal clock ticks after the prescaler.
// - Internal tick source fixed by a build parameter, not a register.
// - Control bits 2..0 pick prescale ratio, divide by two to that power.
// - Event mode advances once per qualifying pin edge, edge bit picks it.
// - Prescaler plays no part when the pin clocks the counter.
// - Counting past FF overflows and raises an internal interrupt request.
// - On overflow the counter reloads from preload and keeps counting.
// - Preload has no reset value; unknown until written.
// - Preload write while stopped is copied into the counter at once.
// - Preload write while running waits for the next overflow.
// - Control bits 7..6 pick the operating mode.
// - Control bit 4 runs the counter; clearing it stops counting.
// - In event and pulse modes, control bit 3 picks the active edge.
// - Event mode: edge bit zero counts rising, one counts falling.
// - Pulse mode waits for active edge, counts, then clears run itself.
// - Mode value 11 selects pulse width measurement.
module eet_timer #(
  parameter bit USE_TICK_IN = 1'b0  // 0: every aclk, 1: int_tick input
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Write address channel
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // Write data channel
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // Write response channel
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // Read address channel
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // Read data channel
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Timer pins
  input  wire logic               int_tick,
  input  wire logic               count_pin,
  output logic                    ovf_irq,
  output eet_pkg::eet_stat_s      status
);
  import eet_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic [6:0] psc_mask(input logic [2:0] sel);
    psc_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == `EET_OFS_COUNT) || (a == `EET_OFS_CTRL);
  endfunction

  // ========================================================================
  // State
  eet_ctrl_s    ctrl_q;
  eet_pw_e      pw_q;
  logic [7:0]   cnt_q, preload_q;
  logic [6:0]   psc_q;
  logic [3:0]   awaddr_q, wstrb_q;
  logic [31:0]  wdata_q, rdata_q;
  logic [1:0]   bresp_q, rresp_q;
  logic         pin_q, irq_q, aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic         wr_go, wr_cnt, wr_ctrl, src_tick, psc_tick, inc, ovf, pw_done;
  logic         pin_rise, pin_fall, act_edge, ret_edge;

  // ========================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign wr_go         = aw_full_q && w_full_q && !bvalid_q;
  assign wr_cnt  = wr_go && wstrb_q[0] && (awaddr_q == `EET_OFS_COUNT);
  assign wr_ctrl = wr_go && wstrb_q[0] && (awaddr_q == `EET_OFS_CTRL);

  // Hold address until the write completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  // Hold data until the write completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `EET_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_ok(awaddr_q) ? `EET_RESP_OKAY : `EET_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  // ========================================================================
  // AXI4-Lite read path, one cycle after the address is taken
  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `EET_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= addr_ok(s_axi_araddr) ? `EET_RESP_OKAY : `EET_RESP_SLVERR;
      case (s_axi_araddr)
        `EET_OFS_COUNT: rdata_q <= {24'h00_0000, cnt_q};
        `EET_OFS_CTRL:  rdata_q <= {24'h00_0000, ctrl_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  // ========================================================================
  // Control register; software write wins over the pulse-mode auto stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= eet_ctrl_s'(`EET_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q     <= eet_ctrl_s'(wdata_q[7:0]);
      ctrl_q.rsv <= 1'b0;
    end else if (pw_done) begin
      ctrl_q.run <= 1'b0;
    end
  end

  // Preload: no reset, so it stays unknown until written
  always_ff @(posedge aclk) begin
    if (wr_cnt) begin
      preload_q <= wdata_q[7:0];
    end
  end

  // ========================================================================
  // Clock sources and prescaler
  assign src_tick = USE_TICK_IN ? int_tick : 1'b1;
  // Prescaler cleared while stopped so each run starts on a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_q.run) begin
      psc_q <= `EET_PSC_RST;
    end else if (src_tick) begin
      psc_q <= psc_q + 7'h01;
    end
  end

  assign psc_tick = src_tick && ((psc_q & psc_mask(ctrl_q.psc)) == psc_mask(ctrl_q.psc));
  // Pin history for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= count_pin;
    end
  end

  assign pin_rise = count_pin && !pin_q;
  assign pin_fall = !count_pin && pin_q;
  // Event mode: 0 rising, 1 falling; pulse mode starts on the opposite sense
  assign act_edge = (ctrl_q.mode == EET_MODE_PULSE) ?
                    (ctrl_q.edge_sel ? pin_rise : pin_fall) :
                    (ctrl_q.edge_sel ? pin_fall : pin_rise);
  assign ret_edge = ctrl_q.edge_sel ? pin_fall : pin_rise;

  // ========================================================================
  // Pulse width sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_q <= EET_PW_IDLE;
    end else if (!ctrl_q.run || ctrl_q.mode != EET_MODE_PULSE) begin
      pw_q <= EET_PW_IDLE;
    end else begin
      case (pw_q)
        EET_PW_IDLE: pw_q <= EET_PW_ARM;
        EET_PW_ARM:  if (act_edge) begin
          pw_q <= EET_PW_MEAS;
        end
        EET_PW_MEAS: if (ret_edge) begin
          pw_q <= EET_PW_IDLE;
        end
        default:     pw_q <= EET_PW_IDLE;
      endcase
    end
  end

  assign pw_done = (pw_q == EET_PW_MEAS) && ret_edge && ctrl_q.run &&
                   (ctrl_q.mode == EET_MODE_PULSE);
  // ========================================================================
  // Increment selection per mode
  always_comb begin
    inc = 1'b0;
    if (ctrl_q.run) begin
      case (ctrl_q.mode)
        EET_MODE_TIMER: inc = psc_tick;
        EET_MODE_EVENT: inc = act_edge;
        EET_MODE_PULSE: inc = (pw_q == EET_PW_MEAS) && !ret_edge && psc_tick;
        default:        inc = 1'b0;
      endcase
    end
  end

  assign ovf = inc && (cnt_q == `EET_COUNT_FULL);
  // Counter: stopped preload writes land at once, overflow reloads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `EET_COUNT_RST;
    end else if (wr_cnt && !ctrl_q.run) begin
      cnt_q <= wdata_q[7:0];
    end else if (ovf) begin
      cnt_q <= preload_q;
    end else if (inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // One-cycle overflow request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ovf;
    end
  end
  assign ovf_irq        = irq_q;
  assign status.running = ctrl_q.run;
  assign status.count   = cnt_q;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_irq_pulse;
    // A reload to FF may overflow again at once; any other reload ends the pulse
    ovf_irq && cnt_q != `EET_COUNT_FULL |=> !ovf_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_irq_cause;
    ovf_irq |-> $past(cnt_q) == `EET_COUNT_FULL && $past(ctrl_q.run);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without full count");
  property p_reload;
    ovf && !(wr_cnt && !ctrl_q.run) |=> cnt_q == $past(preload_q) && ovf_irq;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow");
  property p_stop_copy;
    wr_cnt && !ctrl_q.run |=> cnt_q == $past(wdata_q[7:0]);
  endproperty
  a_stop_copy: assert property (p_stop_copy) else $error("stopped write not copied");
  property p_run_copy;
    wr_cnt && ctrl_q.run && !ovf |=> cnt_q != $past(wdata_q[7:0]) || $past(inc) ||
      $past(cnt_q) == $past(wdata_q[7:0]);
  endproperty
  a_run_copy: assert property (p_run_copy) else $error("running write hit counter");
  property p_hold_stopped;
    !ctrl_q.run && !wr_cnt |=> $stable(cnt_q);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped");
  property p_event_inc;
    ctrl_q.run && ctrl_q.mode == EET_MODE_EVENT && !wr_cnt &&
      (ctrl_q.edge_sel ? pin_fall : pin_rise) && cnt_q != `EET_COUNT_FULL
      |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_event_inc: assert property (p_event_inc) else $error("event edge not counted");
  property p_event_nopsc;
    ctrl_q.run && ctrl_q.mode == EET_MODE_EVENT && !act_edge && !wr_cnt
      |=> $stable(cnt_q);
  endproperty
  a_event_nopsc: assert property (p_event_nopsc) else $error("event count without edge");
  property p_timer_div;
    ctrl_q.run && ctrl_q.mode == EET_MODE_TIMER && ctrl_q.psc != 3'h0 && inc &&
      !wr_ctrl |=> !inc;
  endproperty
  a_timer_div: assert property (p_timer_div) else $error("prescaler did not divide");
  property p_pulse_stop;
    pw_done && !wr_ctrl |=> !ctrl_q.run && !inc;
  endproperty
  a_pulse_stop: assert property (p_pulse_stop) else $error("pulse end did not stop");
  property p_read_count;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `EET_OFS_COUNT
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(cnt_q);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read mismatch");
  c_overflow: cover property (ovf_irq);
  c_pulse_done: cover property (pw_done);
  c_event_wrap: cover property (ctrl_q.mode == EET_MODE_EVENT && ovf);
  c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ==== bench/eet_pin_src.sv ====
// Purpose: far-side pulse source on the timer count pin
// Assumes: pulse lengths counted in aclk cycles
// Notes:   pin rests at idle_lvl between pulses
`timescale 1ns/10ps
`default_nettype none
module eet_pin_src (
  // Clock
  input  wire logic       aclk,
  // Commands from the bench
  input  wire logic       fire,
  input  wire logic       idle_lvl,
  input  wire logic [7:0] width,
  // Pin
  output logic            count_pin
);
  logic [7:0] left_q = 8'h00;
  // ==========================================================================
  // Pulse length counter; pin leaves its rest level while it runs
  always @(posedge aclk) begin
    if (fire) begin
      left_q <= width;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Always driven, so an idle pin never floats
  assign count_pin = idle_lvl ^ (left_q != 8'h00);
endmodule
`default_nettype wire

// ==== bench/eet_timer_tb.sv ====
// Purpose: self-checking bench for the event timer
// Assumes: 10 MHz aclk; AXI4-Lite master acting on rising edges
// Notes:   handshakes judged at the falling edge before the taking edge
`timescale 1ns/10ps
`default_nettype none
`include "eet_regs.svh"
module eet_timer_tb;
  import eet_pkg::*;
  // ==========================================================================
  // Signals
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        fire = 1'b0;
  logic        idle = 1'b0;
  logic [7:0]  width = 8'h00;
  logic        awready, wready, bvalid, arready, rvalid, ovf_irq, count_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  eet_stat_s   status;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // Clock
  always #50 aclk = ~aclk;
  eet_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .int_tick(1'b0), .count_pin(count_pin),
    .ovf_irq(ovf_irq), .status(status));
  eet_pin_src u_src (.aclk(aclk), .fire(fire), .idle_lvl(idle), .width(width),
    .count_pin(count_pin));
  // ==========================================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  function automatic logic [7:0] cw(logic [1:0] m, logic r, logic e, logic [2:0] p);
    return {m, 1'b0, r, e, p};
  endfunction
  // ==========================================================================
  // Bus cycles: payload held until its own ready is seen
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ha, hr;
    logic [1:0] r;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  // Overflow spacing in cycles, seen at falling edges
  task automatic wait_ovf(output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (ovf_irq !== 1'b1);
  endtask
  // One pulse on the pin; count sampled halfway through
  task automatic pulse(input int w, output logic [7:0] mid);
    @(posedge aclk);
    fire <= 1'b1;
    width <= w[7:0];
    @(posedge aclk);
    fire <= 1'b0;
    repeat (w / 2 + 1) @(negedge aclk);
    mid = status.count;
    repeat (w / 2 + 4) @(posedge aclk);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] v, u;
    logic [7:0]  pl, mid, nx;
    int          per, n;
    void'($urandom(32'h12ea81f3));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state and an unmapped place
    rd(`EET_OFS_CTRL, v, `EET_RESP_OKAY);
    chk("ctrl_rst", v, 32'h0);
    wr(4'h8, 8'h55, `EET_RESP_SLVERR);
    rd(4'h8, v, `EET_RESP_SLVERR);
    chk("unmapped", v, 32'h0);
    rd(`EET_OFS_CTRL, v, `EET_RESP_OKAY);
    chk("ctrl_kept", v, 32'h0);
    // Stopped preload write lands in the counter
    pl = 8'($urandom);
    wr(`EET_OFS_COUNT, pl, `EET_RESP_OKAY);
    rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
    chk("preload_copy", v, {24'h0, pl});
    // Timer period for every prescale ratio
    for (int p = 0; p < 8; p++) begin
      wr(`EET_OFS_CTRL, 8'h00, `EET_RESP_OKAY);
      wr(`EET_OFS_COUNT, 8'hF0, `EET_RESP_OKAY);
      wr(`EET_OFS_CTRL, cw(2'b10, 1'b1, 1'b0, p[2:0]), `EET_RESP_OKAY);
      wait_ovf(per);
      wait_ovf(per);
      chk("period", per, 32'(16 << p));
      if (p > 0) chk("reload", {24'h0, status.count}, 32'hF0);
      @(negedge aclk);
      chk("irq_len", {31'h0, ovf_irq}, 32'h0);
    end
    // Running preload write waits for the next overflow
    wr(`EET_OFS_CTRL, 8'h00, `EET_RESP_OKAY);
    wr(`EET_OFS_COUNT, 8'hF0, `EET_RESP_OKAY);
    wr(`EET_OFS_CTRL, cw(2'b10, 1'b1, 1'b0, 3'h0), `EET_RESP_OKAY);
    wr(`EET_OFS_COUNT, 8'hC0, `EET_RESP_OKAY);
    rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
    chk("run_wr", {31'h0, v >= 32'hF0}, 32'h1);
    wait_ovf(per);
    wait_ovf(per);
    chk("new_period", per, 32'd64);
    // Clearing run freezes the count
    wr(`EET_OFS_CTRL, cw(2'b10, 1'b0, 1'b0, 3'h0), `EET_RESP_OKAY);
    rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(`EET_OFS_COUNT, u, `EET_RESP_OKAY);
    chk("frozen", u, v);
    chk("running", {31'h0, status.running}, 32'h0);
    // Event counting on each edge choice, prescaler random
    for (int e = 0; e < 2; e++) begin
      wr(`EET_OFS_CTRL, 8'h00, `EET_RESP_OKAY);
      wr(`EET_OFS_COUNT, 8'hFC, `EET_RESP_OKAY);
      wr(`EET_OFS_CTRL, cw(2'b01, 1'b1, e[0], 3'($urandom)), `EET_RESP_OKAY);
      n = 1 + $urandom % 8;
      pl = 8'hFC;
      repeat (n) begin
        pulse(4 + $urandom % 8, mid);
        nx = (pl == 8'hFF) ? 8'hFC : pl + 8'h01;
        chk("mid", {24'h0, mid}, {24'h0, e ? pl : nx});
        pl = nx;
      end
      rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
      chk("events", v, {24'h0, pl});
    end
    // Idle mode ignores the pin and the clock
    wr(`EET_OFS_CTRL, cw(2'b00, 1'b1, 1'b0, 3'h0), `EET_RESP_OKAY);
    pulse(6, mid);
    rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
    chk("idle_mode", v, {24'h0, pl});
    // Pulse width measurement, both polarities
    for (int e = 0; e < 2; e++) begin
      wr(`EET_OFS_CTRL, 8'h00, `EET_RESP_OKAY);
      idle <= ~e[0];
      wr(`EET_OFS_COUNT, 8'h00, `EET_RESP_OKAY);
      wr(`EET_OFS_CTRL, cw(2'b11, 1'b1, e[0], 3'h0), `EET_RESP_OKAY);
      n = 8 + $urandom % 40;
      pulse(n, mid);
      rd(`EET_OFS_CTRL, v, `EET_RESP_OKAY);
      chk("auto_stop", v, {24'h0, cw(2'b11, 1'b0, e[0], 3'h0)});
      rd(`EET_OFS_COUNT, v, `EET_RESP_OKAY);
      chk("width", {31'h0, v + 1 >= n && v <= n + 1}, 32'h1);
      pulse(6, mid);
      rd(`EET_OFS_COUNT, u, `EET_RESP_OKAY);
      chk("one_shot", u, v);
    end
    conclude();
  end
endmodule
`default_nettype wire
